// ===== src/timer_flags_pkg.sv
// shared offsets, bit positions, reset values and channel functions of the timer status block
package timer_flags_pkg;
  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [7:0] STATUS_OFS       = 8'h08;
  localparam logic [7:0] MASK_OFS         = 8'h0C;
  localparam logic [7:0] FLAGS_OFS        = 8'h10;
  localparam logic [7:0] FLAG_SET_OFS     = 8'h14;
  localparam logic [7:0] FLAG_CLEAR_OFS   = 8'h18;
  localparam logic [7:0] LIMIT_OFS        = 8'h1C;
  localparam logic [7:0] LIMIT_BUF_OFS    = 8'h20;
  localparam logic [7:0] CH_BASE_OFS      = 8'h30;
  localparam logic [7:0] CH_STRIDE        = 8'h10;
  localparam logic [7:0] CH_CTRL_OFS      = 8'h00;
  localparam logic [7:0] CH_VALUE_OFS     = 8'h04;
  localparam logic [7:0] CH_BUFFER_OFS    = 8'h08;
  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int         ST_RUNNING       = 0;
  localparam int         ST_DIRECTION     = 1;
  localparam int         ST_LIMIT_FULL    = 2;
  localparam int         ST_CH_FULL_LSB   = 8;
  localparam int         FL_OVERFLOW      = 0;
  localparam int         FL_UNDERFLOW     = 1;
  localparam int         FL_EVENT_LSB     = 4;
  localparam int         FL_OVERRUN_LSB   = 8;
  localparam logic [31:0] FLAG_VALID      = 32'h0000_0773;
  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [31:0] MASK_RESET      = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RESET     = 32'h0000_0000;
  localparam logic [15:0] LIMIT_RESET     = 16'hFFFF;
  localparam logic [15:0] LIMIT_BUF_RESET = 16'h0000;
  localparam logic [15:0] CH_VALUE_RESET  = 16'h0000;
  // ***************************************************************
  // channel function field
  // ***************************************************************
  typedef enum logic [1:0] {FN_OFF, FN_CAPTURE, FN_COMPARE, FN_PWM} channel_function_e;
endpackage

// ===== src/reg_access_if.sv
// register access strobes between the bus front end and the register file
`timescale 1ns/1ps
interface reg_access_if #(
  parameter int ADDR_W = 8
);
  logic              wr;
  logic              rd;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wdata;
  logic [31:0]       rdata;
  modport port (output wr, output rd, output addr, output wdata, input rdata);
  modport regs (input wr, input rd, input addr, input wdata, output rdata);
endinterface

// ===== src/ahb_reg_port.sv
// ahb-lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/1ps
module ahb_reg_port #(
  parameter int ADDR_W = 8
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  reg_access_if.port       bus
);
  // ***************************************************************
  // address phase capture
  // ***************************************************************
  logic              accept;
  logic              wr_pend;
  logic              rd_pend;
  logic [ADDR_W-1:0] addr_q;

  if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad_width
    $error("ahb_reg_port: ADDR_W must lie in 7..32");
  end

  // hsize is not decoded: every transfer is served as a whole word
  assign accept = hsel & hready & htrans[1];

  // one data phase pending at most
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= '0;
    end else begin
      wr_pend <= accept & hwrite;
      rd_pend <= accept & ~hwrite;
      if (accept) begin
        addr_q <= haddr[ADDR_W-1:0];
      end
    end
  end

  // reads stall one cycle so a write just before is already visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= ~(accept & ~hwrite);
      hresp     <= 1'b0;
      if (rd_pend) begin
        hrdata <= bus.rdata;
      end
    end
  end

  // write lands at the end of its data phase
  assign bus.wr    = wr_pend;
  assign bus.rd    = rd_pend;
  assign bus.addr  = addr_q;
  assign bus.wdata = hwdata;
endmodule // ahb_reg_port

// ===== src/capture_compare_slot.sv
// one channel: function field, live value, buffer and capture depth
`timescale 1ns/1ps
module capture_compare_slot (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ctrl_wr,
  input  wire logic        value_wr,
  input  wire logic        buffer_wr,
  input  wire logic        value_rd,
  input  wire logic [15:0] wdata,
  input  wire logic        update_event,
  input  wire logic        capture_strobe,
  input  wire logic [15:0] capture_data,
  output timer_flags_pkg::channel_function_e function_q,
  output logic      [15:0] value,
  output logic      [15:0] buffer,
  output logic             buffer_full,
  output logic             overrun
);
  logic [1:0] depth;
  logic       is_cap;
  logic       is_cmp;

  assign is_cap = (function_q == timer_flags_pkg::FN_CAPTURE);
  assign is_cmp = (function_q == timer_flags_pkg::FN_COMPARE) || (function_q == timer_flags_pkg::FN_PWM);

  // function field
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      function_q <= timer_flags_pkg::FN_OFF;
    end else if (ctrl_wr) begin
      function_q <= timer_flags_pkg::channel_function_e'(wdata[1:0]);
    end
  end

  // buffer valid: off-write clears, new buffer write beats update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buffer_full <= 1'b0;
    end else if (ctrl_wr && wdata[1:0] == 2'(timer_flags_pkg::FN_OFF)) begin
      buffer_full <= 1'b0;
    end else if (buffer_wr && is_cmp) begin
      buffer_full <= 1'b1;
    end else if (update_event && buffer_full) begin
      buffer_full <= 1'b0;
    end
  end

  // capture pair or compare transfer; a capture beats a same-cycle read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value   <= timer_flags_pkg::CH_VALUE_RESET;
      buffer  <= timer_flags_pkg::CH_VALUE_RESET;
      depth   <= 2'h0;
      overrun <= 1'b0;
    end else begin
      overrun <= 1'b0;
      if (ctrl_wr) begin
        depth <= 2'h0;
      end else if (is_cap && capture_strobe) begin
        case (depth)
          2'h0: begin
            value <= capture_data;
            depth <= 2'h1;
          end
          2'h1: begin
            buffer <= capture_data;
            depth  <= 2'h2;
          end
          default: begin
            value   <= buffer;
            buffer  <= capture_data;
            overrun <= 1'b1;
          end
        endcase
      end else if (is_cap && value_rd && depth != 2'h0) begin
        value <= buffer;
        depth <= depth - 2'h1;
      end else if (!is_cap) begin
        if (value_wr) begin
          value <= wdata;
        end else if (update_event && buffer_full) begin
          value <= buffer;
        end
        if (buffer_wr) begin
          buffer <= wdata;
        end
      end
    end
  end
endmodule // capture_compare_slot

// ===== src/timer_status_and_interrupt_flags.sv
// timer status, limit buffering, channel slots, interrupt flags and request
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
// Behaviour
// - limit buffer full bit; cleared by limit write
// - update copies buffered limit, drops full
// - channel buffer full cleared by off function
// - update moves channel buffer into live value
// - running status bit, resets to zero
// - mask bits 10..8 gate capture overrun
// - mask bits 6..4, 1, 0 gate events
// - overrun flag when capture displaces unread value
// - read-only flags set by hardware events
// - set port bits 10..8 set overrun flags
// - set port bits 6..4 set channel events
// - set port bits 0, 1 set overflow/underflow
// - clear port clears flags written one
module timer_status_and_interrupt_flags #(
  parameter int ADDR_W   = 8,
  parameter int CHANNELS = 3
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        update_event,
  input  wire logic        counter_running,
  input  wire logic        count_down,
  input  wire logic        overflow_event,
  input  wire logic        underflow_event,
  input  wire logic [2:0]  channel_event,
  input  wire logic [2:0]  capture_strobe,
  input  wire logic [15:0] capture_data,
  output logic      [15:0] limit_value,
  output logic      [47:0] compare_values,
  output logic             irq
);
  // ***************************************************************
  // bus front end
  // ***************************************************************
  reg_access_if #(.ADDR_W(ADDR_W)) acc ();

  if (CHANNELS != 3) begin : g_bad_channels
    $error("timer_status_and_interrupt_flags: flag layout serves exactly 3 channels");
  end

  ahb_reg_port #(.ADDR_W(ADDR_W)) u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .bus       (acc.port)
  );

  // ***************************************************************
  // decode
  // ***************************************************************
  logic        wr_mask;
  logic        wr_set;
  logic        wr_clear;
  logic        wr_limit;
  logic        wr_limit_buf;
  logic [31:0] wmask;
  logic [31:0] mask;
  logic [31:0] flags;
  logic [31:0] hw_set;
  logic [31:0] sw_set;
  logic [31:0] sw_clear;
  logic [15:0] limit_buffer;
  logic        limit_buffer_full;
  logic        running;
  logic        direction;
  logic [2:0]  ch_full;
  logic [2:0]  ch_overrun;
  logic [2:0]  ch_ctrl_wr;
  logic [15:0] ch_buffer [CHANNELS];
  logic [31:0] ch_rdata  [CHANNELS];
  logic [31:0] reg_rdata;
  logic [31:0] status_word;

  // unused positions are forced to zero whatever software writes
  assign wmask        = acc.wdata & timer_flags_pkg::FLAG_VALID;
  assign wr_mask      = acc.wr && acc.addr == ADDR_W'(timer_flags_pkg::MASK_OFS);
  assign wr_set       = acc.wr && acc.addr == ADDR_W'(timer_flags_pkg::FLAG_SET_OFS);
  assign wr_clear     = acc.wr && acc.addr == ADDR_W'(timer_flags_pkg::FLAG_CLEAR_OFS);
  assign wr_limit     = acc.wr && acc.addr == ADDR_W'(timer_flags_pkg::LIMIT_OFS);
  assign wr_limit_buf = acc.wr && acc.addr == ADDR_W'(timer_flags_pkg::LIMIT_BUF_OFS);

  // ***************************************************************
  // channel slots
  // ***************************************************************
  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    localparam logic [ADDR_W-1:0] BASE = ADDR_W'(timer_flags_pkg::CH_BASE_OFS) + ADDR_W'(i) *
                                         ADDR_W'(timer_flags_pkg::CH_STRIDE);
    logic sel_ctrl;
    logic sel_value;
    logic sel_buffer;
    timer_flags_pkg::channel_function_e fn;
    logic [15:0] value;

    assign sel_ctrl   = acc.addr == BASE + ADDR_W'(timer_flags_pkg::CH_CTRL_OFS);
    assign sel_value  = acc.addr == BASE + ADDR_W'(timer_flags_pkg::CH_VALUE_OFS);
    assign sel_buffer = acc.addr == BASE + ADDR_W'(timer_flags_pkg::CH_BUFFER_OFS);
    assign ch_ctrl_wr[i] = acc.wr && sel_ctrl;

    capture_compare_slot u_slot (
      .hclk           (hclk),
      .hresetn        (hresetn),
      .ctrl_wr        (acc.wr && sel_ctrl),
      .value_wr       (acc.wr && sel_value),
      .buffer_wr      (acc.wr && sel_buffer),
      .value_rd       (acc.rd && sel_value),
      .wdata          (acc.wdata[15:0]),
      .update_event   (update_event),
      .capture_strobe (capture_strobe[i]),
      .capture_data   (capture_data),
      .function_q     (fn),
      .value          (value),
      .buffer         (ch_buffer[i]),
      .buffer_full    (ch_full[i]),
      .overrun        (ch_overrun[i])
    );

    assign compare_values[16*i +: 16] = value;
    assign ch_rdata[i] = sel_ctrl   ? {30'h0000_0000, 2'(fn)} :
                         sel_value  ? {16'h0000, value} :
                         sel_buffer ? {16'h0000, ch_buffer[i]} : 32'h0000_0000;
  end

  // ***************************************************************
  // limit and its buffer
  // ***************************************************************
  // a direct limit write discards any pending buffered value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      limit_value       <= timer_flags_pkg::LIMIT_RESET;
      limit_buffer      <= timer_flags_pkg::LIMIT_BUF_RESET;
      limit_buffer_full <= 1'b0;
    end else begin
      if (wr_limit_buf) begin
        limit_buffer <= acc.wdata[15:0];
      end
      if (wr_limit) begin
        limit_value       <= acc.wdata[15:0];
        limit_buffer_full <= 1'b0;
      end else if (wr_limit_buf) begin
        limit_buffer_full <= 1'b1;
      end else if (update_event && limit_buffer_full) begin
        limit_value       <= limit_buffer;
        limit_buffer_full <= 1'b0;
      end
    end
  end

  // counter state sampled from same-clock core logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      running   <= 1'b0;
      direction <= 1'b0;
    end else begin
      running   <= counter_running;
      direction <= count_down;
    end
  end

  // ***************************************************************
  // interrupt mask, flags and request
  // ***************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask <= timer_flags_pkg::MASK_RESET;
    end else if (wr_mask) begin
      mask <= wmask;
    end
  end

  assign hw_set = ({29'h0000_0000, ch_overrun} << timer_flags_pkg::FL_OVERRUN_LSB) |
                  ({29'h0000_0000, channel_event} << timer_flags_pkg::FL_EVENT_LSB) |
                  ({31'h0000_0000, underflow_event} << timer_flags_pkg::FL_UNDERFLOW) |
                  ({31'h0000_0000, overflow_event} << timer_flags_pkg::FL_OVERFLOW);
  assign sw_set   = wr_set ? wmask : 32'h0000_0000;
  assign sw_clear = wr_clear ? wmask : 32'h0000_0000;

  // sets applied after the clear so a same-cycle event survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= timer_flags_pkg::FLAGS_RESET;
    end else begin
      flags <= (flags & ~sw_clear) | hw_set | sw_set;
    end
  end

  // registered: irq follows the flags by one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & mask);
    end
  end

  // ***************************************************************
  // read mux
  // ***************************************************************
  assign status_word = {21'h00_0000, ch_full, 5'h00, limit_buffer_full, direction, running};

  always_comb begin
    reg_rdata = 32'h0000_0000;
    for (int i = 0; i < CHANNELS; i++) begin
      reg_rdata = reg_rdata | ch_rdata[i];
    end
    case (acc.addr)
      ADDR_W'(timer_flags_pkg::STATUS_OFS):    reg_rdata = status_word;
      ADDR_W'(timer_flags_pkg::MASK_OFS):      reg_rdata = mask;
      ADDR_W'(timer_flags_pkg::FLAGS_OFS):     reg_rdata = flags;
      ADDR_W'(timer_flags_pkg::LIMIT_OFS):     reg_rdata = {16'h0000, limit_value};
      ADDR_W'(timer_flags_pkg::LIMIT_BUF_OFS): reg_rdata = {16'h0000, limit_buffer};
      default:                                 reg_rdata = reg_rdata;
    endcase
  end
  assign acc.rdata = reg_rdata;

  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_limit_clear;
    @(posedge hclk) disable iff (!hresetn) wr_limit |=> !limit_buffer_full;
  endproperty
  a_limit_clear: assert property (p_limit_clear) else $error("limit write left buffer full");

  property p_limit_copy;
    @(posedge hclk) disable iff (!hresetn)
      update_event && limit_buffer_full && !wr_limit && !wr_limit_buf
      |=> limit_value == $past(limit_buffer) && !limit_buffer_full;
  endproperty
  a_limit_copy: assert property (p_limit_copy) else $error("update did not move limit buffer");

  property p_off_clears;
    @(posedge hclk) disable iff (!hresetn)
      ch_ctrl_wr[0] && acc.wdata[1:0] == 2'h0 |=> !ch_full[0] ##1 status_word[timer_flags_pkg::ST_CH_FULL_LSB] == 1'b0;
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("off function kept buffer full");

  property p_cmp_copy;
    @(posedge hclk) disable iff (!hresetn)
      update_event && ch_full[0] && !acc.wr |=> compare_values[15:0] == $past(ch_buffer[0]) && !ch_full[0];
  endproperty
  a_cmp_copy: assert property (p_cmp_copy) else $error("update did not move channel buffer");

  property p_running;
    @(posedge hclk) disable iff (!hresetn)
      counter_running ##1 counter_running |-> status_word[timer_flags_pkg::ST_RUNNING];
  endproperty
  a_running: assert property (p_running) else $error("running status wrong");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn) ##1 irq == $past(|(flags & mask));
  endproperty
  a_irq: assert property (p_irq) else $error("irq does not follow enabled flags");

  property p_overrun;
    @(posedge hclk) disable iff (!hresetn)
      ch_overrun[1] |=> flags[timer_flags_pkg::FL_OVERRUN_LSB + 1] ##1 flags[timer_flags_pkg::FL_OVERRUN_LSB + 1] || $past(wr_clear);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun flag not set");

  property p_hw_set;
    @(posedge hclk) disable iff (!hresetn)
      overflow_event || channel_event[2] |=> flags[timer_flags_pkg::FL_OVERFLOW] || flags[timer_flags_pkg::FL_EVENT_LSB + 2];
  endproperty
  a_hw_set: assert property (p_hw_set) else $error("hardware event lost");

  property p_sw_set;
    @(posedge hclk) disable iff (!hresetn) wr_set |=> (flags & $past(wmask)) == $past(wmask);
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("set port did not set flags");

  property p_clear;
    @(posedge hclk) disable iff (!hresetn) wr_clear && hw_set == 32'h0 |=> (flags & $past(wmask)) == 32'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear port did not clear");

  property p_zero_set;
    @(posedge hclk) disable iff (!hresetn) wr_set && wmask == 32'h0 && hw_set == 32'h0 |=> flags == $past(flags);
  endproperty
  a_zero_set: assert property (p_zero_set) else $error("zero set write changed flags");

  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) !irq ##1 irq);
  c_limit_copy: cover property (@(posedge hclk) disable iff (!hresetn) update_event && limit_buffer_full);
  c_overrun: cover property (@(posedge hclk) disable iff (!hresetn) |ch_overrun);
  c_set_wins: cover property (@(posedge hclk) disable iff (!hresetn) overflow_event && wr_clear && acc.wdata[0]);
endmodule // timer_status_and_interrupt_flags

// ===== testbench/ahb_master_model.sv
// ahb-lite master model standing in for the processor
`timescale 1ns/1ps
module ahb_master_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  // idle bus from time zero, whole words only
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // bounded wait so a stuck slave ends the run instead of hanging it
  task automatic wait_ready();
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) tb_top.time_out();
  endtask
  // single transfer; a read leaves hwdata toggled so stale data never looks valid
  task automatic transfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    wait_ready();
    r = hrdata;
  endtask
endmodule // ahb_master_model

// ===== testbench/tb_top.sv
// self-checking bench of the timer status and interrupt flag block
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] st_a    = {24'h0, timer_flags_pkg::STATUS_OFS};
  localparam logic [31:0] mask_a  = {24'h0, timer_flags_pkg::MASK_OFS};
  localparam logic [31:0] flags_a = {24'h0, timer_flags_pkg::FLAGS_OFS};
  localparam logic [31:0] set_a   = {24'h0, timer_flags_pkg::FLAG_SET_OFS};
  localparam logic [31:0] clr_a   = {24'h0, timer_flags_pkg::FLAG_CLEAR_OFS};
  localparam logic [31:0] lim_a   = {24'h0, timer_flags_pkg::LIMIT_OFS};
  localparam logic [31:0] lbuf_a  = {24'h0, timer_flags_pkg::LIMIT_BUF_OFS};
  localparam logic [31:0] valid   = timer_flags_pkg::FLAG_VALID;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, r, m, f, base;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [8:0]  evt = 9'h0;
  logic        running = 1'b0;
  logic        down = 1'b0;
  logic [15:0] cdata = 16'h0;
  logic [15:0] limit_value, v;
  logic [47:0] compare_values;
  int          failures = 0;
  int          check_count = 0;
  // free-running bus clock, 8 ns period
  always #4 hclk = ~hclk;
  ahb_master_model i_master (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  timer_status_and_interrupt_flags i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .update_event(evt[8]), .counter_running(running), .count_down(down),
    .overflow_event(evt[6]), .underflow_event(evt[7]), .channel_event(evt[5:3]), .capture_strobe(evt[2:0]),
    .capture_data(cdata), .limit_value(limit_value), .compare_values(compare_values), .irq(irq));
  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic summarize();
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic time_out();
    failures++;
    summarize();
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    i_master.transfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [31:0] a);
    i_master.transfer(1'b0, a, 32'h0, r);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    rd(a);
    chk(r, exp);
  endtask
  // one-cycle event pulse; returns one edge later so its effect has landed
  task automatic pulse(input logic [8:0] p);
    evt <= p;
    @(posedge hclk);
    evt <= 9'h0;
    @(posedge hclk);
  endtask
  function automatic logic [31:0] flag_of(int i);
    return (i < 3) ? 32'h10 << i : 32'h1 << (i - 3);
  endfunction
  function automatic logic exp_irq(logic [31:0] mk, logic [31:0] fl);
    return |(mk & fl & valid);
  endfunction
  // main sequence
  initial begin
    v = 16'($urandom(32'hB5A14DC2));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(mask_a, 32'h0);
    rdc(flags_a, 32'h0);
    rdc(st_a, 32'h0);
    chk(limit_value, 16'hFFFF);
    wr(mask_a, 32'hFFFF_FFFF);
    rdc(mask_a, valid);
    for (int b = 0; b < 11; b++) begin
      if (valid[b]) begin
        wr(clr_a, valid);
        wr(set_a, 32'h0);
        rdc(flags_a, 32'h0);
        chk(irq, 1'b0);
        wr(set_a, 32'h1 << b);
        rdc(flags_a, 32'h1 << b);
        rdc(set_a, 32'h0);
        chk(irq, 1'b1);
      end
    end
    for (int i = 0; i < 5; i++) begin
      wr(clr_a, valid);
      pulse(9'h8 << i);
      rdc(flags_a, flag_of(i));
    end
    // overflow pulse lands on the same edge as the clear write (its data phase end)
    fork
      wr(clr_a, 32'h1);
      begin
        @(posedge hclk);
        pulse(9'h40);
      end
    join
    rdc(flags_a, 32'h3);
    repeat (20) begin
      m = $urandom & valid;
      f = $urandom & valid;
      running <= 1'($urandom);
      down <= 1'($urandom);
      cdata <= 16'($urandom);
      wr(clr_a, valid);
      wr(mask_a, m);
      chk(hresp, 1'b0);
      wr(set_a, f);
      rdc(flags_a, f);
      chk(irq, exp_irq(m, f));
      rd(st_a);
      chk(r[1:0], {down, running});
    end
    wr(lbuf_a, {16'h0, v});
    rd(st_a);
    chk(r[2], 1'b1);
    pulse(9'h100);
    chk(limit_value, v);
    rd(st_a);
    chk(r[2], 1'b0);
    wr(lbuf_a, {16'h0, ~v});
    wr(lim_a, 32'h55);
    rd(st_a);
    chk(r[2], 1'b0);
    chk(limit_value, 16'h55);
    for (int i = 0; i < 3; i++) begin
      base = {24'h0, timer_flags_pkg::CH_BASE_OFS + 8'(i) * timer_flags_pkg::CH_STRIDE};
      v = 16'($urandom);
      wr(base, (i == 2) ? 32'(timer_flags_pkg::FN_PWM) : 32'(timer_flags_pkg::FN_COMPARE));
      wr(base + 32'(timer_flags_pkg::CH_BUFFER_OFS), {16'h0, v});
      rd(st_a);
      chk(r[8 + i], 1'b1);
      pulse(9'h100);
      chk(compare_values[16 * i +: 16], v);
      wr(base + 32'(timer_flags_pkg::CH_BUFFER_OFS), {16'h0, ~v});
      wr(base, 32'(timer_flags_pkg::FN_OFF));
      rd(st_a);
      chk(r[8 + i], 1'b0);
      wr(base, 32'(timer_flags_pkg::FN_CAPTURE));
      wr(clr_a, valid);
      evt <= 9'h1 << i;
      repeat (3) @(posedge hclk);
      evt <= 9'h0;
      rd(flags_a);
      chk(r[8 + i], 1'b1);
      rdc(base + 32'(timer_flags_pkg::CH_VALUE_OFS), {16'h0, cdata});
    end
    summarize();
  end
endmodule // tb_top
